/* core/bus_port_params.svh */
/*
  Offsets, field positions, reset values and fixed counts for the
  multiplexed address/data bus port.
  Assumes byte addressing on a 32-bit AHB-Lite register bus.
*/
`ifndef BUS_PORT_PARAMS_SVH
`define BUS_PORT_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_ADDR        8'h04
`define OFS_WDATA       8'h08
`define OFS_CMD         8'h0C
`define OFS_STATUS      8'h10
`define OFS_RBUF        8'h20

// Control fields
`define CTRL_WIDTH_LSB  0
`define CTRL_BIG_END    2
`define CTRL_STB_HOLD   3
`define CTRL_RESET      32'h0000_0000

// Command fields
`define CMD_START       0
`define CMD_READ        1
`define CMD_BURST       2
`define CMD_SIZE_LSB    3
`define CMD_MISS        5
`define CMD_FETCH       6

// Status fields
`define STS_BUSY        0
`define STS_DONE        1
`define STS_CFG_LSB     4

// Transfer sizes in bytes
`define WORD_BYTES      3'h4
`define BURST_BYTES     5'h10

`endif

/* core/bus_port_pkg.sv */
/*
  Types shared by the bus port files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bus_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_HOLD = 3'b010,
    ST_XFER = 3'b011,
    ST_GAP  = 3'b100
  } bus_state_t;

  typedef enum logic [1:0] {
    PORT_32 = 2'b00,
    PORT_16 = 2'b01,
    PORT_8  = 2'b10
  } port_width_t;

endpackage

/* core/read_buffer_mem.sv */
/*
  Four-word read buffer with registered read data.
  Assumes one clock; write and read may hit the same word in one cycle,
  in which case the old word is read.
*/
`timescale 1ns/10ps

module read_buffer_mem (
  input  wire logic        clk_sys,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [1:0]  rd_idx,
  output logic      [31:0] rd_data
);

  logic [31:0] words [0:3];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      words[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= words[rd_idx];
  end

endmodule // read_buffer_mem

/* core/muxed_addr_data_bus_port.sv */
/*
  Multiplexed address/data bus port with an AHB-Lite register slave.
  Assumes external address latches and memory that answers with a
  level acknowledge held until the read/write strobe is released.
*/
// What this block does
// - Write data phase drives store data
// - Read single or four-word burst into buffer
// - Byte lanes from size, width, byte order
// - Meaningful low bits depend on port width
// - Low address shows current datum throughout
// - Single: exact address, then step pieces
// - Burst: low address counts from zero
// - Low pins sampled as config at reset
// - Diag shows cache miss in address phase on reads
// - Diag shows fetch type in next slot on reads
// - Latch strobe marks valid address
// - Drive permit once bus released on reads
// - Active-low lane strobes on low bits
// - Control bit holds strobes inactive on reads
// - Same lines carry data after address
// - High address bits on upper lines
`timescale 1ns/10ps
`include "bus_port_params.svh"

module muxed_addr_data_bus_port
  import bus_port_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  input  wire logic [3:0]  low_addr_in,
  output logic      [3:0]  low_addr_out,
  output logic             low_addr_oe,
  output logic             ale,
  output logic             diag,
  output logic             data_drive_permit,
  output logic             rd_n,
  output logic             wr_n,
  input  wire logic        data_ack
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] piece_bytes(input logic [1:0] w);
    unique case (w)
      PORT_16: piece_bytes = 3'h2;
      PORT_8:  piece_bytes = 3'h1;
      default: piece_bytes = 3'h4;
    endcase
  endfunction

  // Active-high lane set for n bytes at offset off
  function automatic logic [3:0] lane_set(input logic [1:0] off,
                                          input logic [2:0] n,
                                          input logic       big);
    logic [2:0] i3;
    lane_set = 4'h0;
    for (int i = 0; i < 4; i++) begin
      i3 = 3'(i);
      if (i3 >= {1'b0, off} && i3 < ({1'b0, off} + n)) begin
        if (big) begin
          lane_set[3 - i] = 1'b1;
        end else begin
          lane_set[i] = 1'b1;
        end
      end
    end
  endfunction

  // Bit shift of a piece within its word
  function automatic logic [4:0] lane_shift(input logic [1:0] off,
                                            input logic [2:0] n,
                                            input logic       big);
    logic [2:0] lane;
    lane = big ? 3'(3'h4 - {1'b0, off} - n) : {1'b0, off};
    lane_shift = {lane[1:0], 3'b000};
  endfunction

  function automatic logic [31:0] piece_mask(input logic [2:0] n);
    unique case (n)
      3'h1:    piece_mask = 32'h0000_00FF;
      3'h2:    piece_mask = 32'h0000_FFFF;
      default: piece_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reset configuration

  logic [31:0] ad_meta;
  logic [31:0] ad_s;
  logic        ack_meta;
  logic        ack_s;
  logic [3:0]  cfg_meta;
  logic [3:0]  cfg_s;
  logic [3:0]  reset_cfg;
  logic        cfg_taken;

  always_ff @(posedge clk_sys) begin
    ad_meta  <= ad_in;
    ad_s     <= ad_meta;
    ack_meta <= data_ack;
    ack_s    <= ack_meta;
    cfg_meta <= low_addr_in;
    cfg_s    <= cfg_meta;
  end

  // Pins are still inputs on the first edge after release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reset_cfg <= 4'h0;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      reset_cfg <= cfg_s;
      cfg_taken <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register slave

  logic [31:0] ctrl;
  logic [31:0] xfer_addr;
  logic [31:0] wdata;
  logic [6:0]  cmd;
  logic        start_req;
  logic        done_clr;
  logic        busy;
  logic        done;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  reg_ofs;
  logic [31:0] rbuf_word;
  logic        accept;

  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      reg_ofs   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend <= accept && hwrite;
      rd_pend <= accept && !hwrite;
      if (accept) begin
        reg_ofs <= haddr[7:0];
      end
      // One wait state lets the buffer read settle into a register
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rd_pend) begin
        unique case (reg_ofs)
          `OFS_CTRL:   hrdata <= ctrl;
          `OFS_ADDR:   hrdata <= xfer_addr;
          `OFS_WDATA:  hrdata <= wdata;
          `OFS_CMD:    hrdata <= {25'h000_0000, cmd};
          `OFS_STATUS: hrdata <= {24'h00_0000, reset_cfg, 2'b00, done, busy};
          8'h20, 8'h24, 8'h28, 8'h2C: hrdata <= rbuf_word;
          default:     hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl      <= `CTRL_RESET;
      xfer_addr <= 32'h0000_0000;
      wdata     <= 32'h0000_0000;
      cmd       <= 7'h00;
      start_req <= 1'b0;
      done_clr  <= 1'b0;
    end else begin
      start_req <= 1'b0;
      done_clr  <= 1'b0;
      if (wr_pend) begin
        unique case (reg_ofs)
          `OFS_CTRL:  ctrl <= {28'h000_0000, hwdata[3:0]};
          `OFS_ADDR:  xfer_addr <= hwdata;
          `OFS_WDATA: wdata <= hwdata;
          `OFS_CMD: begin
            if (!busy) begin
              cmd       <= hwdata[6:0];
              start_req <= hwdata[`CMD_START];
            end
          end
          `OFS_STATUS: done_clr <= hwdata[`STS_DONE];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus transaction engine

  bus_state_t  state;
  logic [1:0]  pw;
  logic        big;
  logic [2:0]  pbytes;
  logic [2:0]  dbytes;
  logic        is_rd;
  logic        is_burst;
  logic [4:0]  remain;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [4:0]  sh;
  logic [2:0]  wn;
  logic [3:0]  lanes;
  logic        buf_we;
  logic        wide;
  logic [31:0] wr_piece;

  assign pw     = ctrl[`CTRL_WIDTH_LSB +: 2];
  assign big    = ctrl[`CTRL_BIG_END];
  assign pbytes = piece_bytes(pw);
  // Size code 3 taken as a word, so a transfer always ends
  assign dbytes = cmd[`CMD_SIZE_LSB + 1] ? 3'h4
                                         : 3'(3'h1 << cmd[`CMD_SIZE_LSB]);
  // Piece width on the lines: the datum if narrower than the port, outside bursts
  assign wn     = (dbytes < pbytes && !is_burst) ? dbytes : pbytes;
  assign sh     = lane_shift(low_addr_out[1:0], wn, big);
  // A full-width port keeps each byte on its own lane
  assign wide     = (pw == PORT_32);
  assign wr_piece = wide ? (wdata & (piece_mask(wn) << sh))
                         : ((wdata >> sh) & piece_mask(wn));
  assign next_acc = acc | (wide ? (ad_s & (piece_mask(wn) << sh))
                                : ((ad_s & piece_mask(wn)) << sh));

  always_comb begin
    if (cmd[`CMD_BURST] && cmd[`CMD_READ]) begin
      lanes = 4'hF;
    end else begin
      lanes = lane_set(xfer_addr[1:0], dbytes, big);
    end
    if (cmd[`CMD_READ] && ctrl[`CTRL_STB_HOLD]) begin
      lanes = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state             <= ST_IDLE;
      is_rd             <= 1'b0;
      is_burst          <= 1'b0;
      remain            <= 5'h00;
      acc               <= 32'h0000_0000;
      busy              <= 1'b0;
      done              <= 1'b0;
      ad_out            <= 32'h0000_0000;
      ad_oe             <= 1'b0;
      low_addr_out      <= 4'h0;
      low_addr_oe       <= 1'b0;
      ale               <= 1'b0;
      diag              <= 1'b0;
      data_drive_permit <= 1'b0;
      rd_n              <= 1'b1;
      wr_n              <= 1'b1;
    end else begin
      // Completion outranks a clear arriving in the same cycle
      if (done_clr) begin
        done <= 1'b0;
      end
      low_addr_oe <= cfg_taken;
      unique case (state)
        ST_IDLE: begin
          if (start_req) begin
            is_rd    <= cmd[`CMD_READ];
            is_burst <= cmd[`CMD_READ] && cmd[`CMD_BURST];
            acc      <= 32'h0000_0000;
            busy     <= 1'b1;
            done     <= 1'b0;
            ale      <= 1'b1;
            ad_oe    <= 1'b1;
            ad_out   <= {xfer_addr[31:4], ~lanes};
            if (cmd[`CMD_READ] && cmd[`CMD_BURST]) begin
              low_addr_out <= 4'h0;
              remain       <= `BURST_BYTES;
            end else begin
              low_addr_out <= xfer_addr[3:0];
              // A datum narrower than the port is one piece
              remain       <= {2'b00, dbytes};
            end
            diag  <= cmd[`CMD_READ] && cmd[`CMD_MISS];
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          ale   <= 1'b0;
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          if (is_rd) begin
            ad_oe             <= 1'b0;
            data_drive_permit <= 1'b1;
            diag              <= cmd[`CMD_FETCH];
            rd_n              <= 1'b0;
          end else begin
            ad_out <= wr_piece;
            wr_n   <= 1'b0;
          end
          state <= ST_XFER;
        end
        ST_XFER: begin
          if (ack_s) begin
            if (is_rd) begin
              acc <= next_acc;
            end
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
            low_addr_out <= low_addr_out + {1'b0, wn};
            remain       <= remain - {2'b00, wn};
            state        <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (low_addr_out[1:0] == 2'b00) begin
            acc <= 32'h0000_0000;
          end
          if (!ack_s) begin
            if (remain == 5'h00) begin
              ad_oe             <= 1'b0;
              data_drive_permit <= 1'b0;
              diag              <= 1'b0;
              busy              <= 1'b0;
              done              <= 1'b1;
              state             <= ST_IDLE;
            end else if (is_rd) begin
              rd_n  <= 1'b0;
              state <= ST_XFER;
            end else begin
              ad_out <= wr_piece;
              wr_n   <= 1'b0;
              state  <= ST_XFER;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign buf_we = (state == ST_XFER) && ack_s && is_rd;

  ////////////////////////////////////////////////////////////////////////
  // Read buffer

  read_buffer_mem u_rbuf (
    .clk_sys (clk_sys),
    .wr_en   (buf_we),
    .wr_idx  (low_addr_out[3:2]),
    .wr_data (next_acc),
    .rd_idx  (haddr[3:2]),
    .rd_data (rbuf_word)
  );

endmodule // muxed_addr_data_bus_port

/* testbench/bus_port_checker.sv */
/*
  Pin-level assertions for the bus port.
  Bound to every instance of muxed_addr_data_bus_port.
*/
`timescale 1ns/10ps

module bus_port_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic [3:0]  low_addr_out,
  input wire logic        low_addr_oe,
  input wire logic        ale,
  input wire logic        data_drive_permit,
  input wire logic        rd_n,
  input wire logic        wr_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_addr;
    ale ##1 (!ale && ad_oe);
  endsequence
  sequence s_piece;
    (!rd_n || !wr_n) ##1 (!rd_n || !wr_n);
  endsequence

  property p_ale_pulse; ale |-> s_addr; endproperty
  a_ale_pulse: assert property (p_ale_pulse)
    else $error("address phase not one cycle");
  property p_addr_hold; ale |=> $stable(ad_out[31:4]); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("high address moved after latch strobe");
  property p_ale_drv; ale |-> ad_oe && low_addr_oe && rd_n && wr_n;
  endproperty
  a_ale_drv: assert property (p_ale_drv)
    else $error("latch strobe without address driven");
  property p_data_slot; s_addr |=> (!rd_n || !wr_n); endproperty
  a_data_slot: assert property (p_data_slot)
    else $error("no data slot after address phase");
  property p_permit; data_drive_permit |-> !ad_oe; endproperty
  a_permit: assert property (p_permit)
    else $error("permit while bus still driven");
  property p_rd; !rd_n |-> data_drive_permit; endproperty
  a_rd: assert property (p_rd)
    else $error("read strobe without permit");
  property p_wr; !wr_n |-> ad_oe && !data_drive_permit; endproperty
  a_wr: assert property (p_wr)
    else $error("write slot without store data driven");
  property p_low; s_piece |-> $stable(low_addr_out); endproperty
  a_low: assert property (p_low)
    else $error("low address moved inside a piece");
endmodule // bus_port_checker

bind muxed_addr_data_bus_port bus_port_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ad_out(ad_out), .ad_oe(ad_oe),
  .low_addr_out(low_addr_out), .low_addr_oe(low_addr_oe), .ale(ale),
  .data_drive_permit(data_drive_permit), .rd_n(rd_n), .wr_n(wr_n));

/* testbench/ext_mem_model.sv */
/*
  Memory side: address latch, memory and reset straps.
  Acks each strobe 2 or 6 cycles after it falls; word data = low address x8.
*/
`timescale 1ns/10ps

module ext_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        slow,
  input  wire logic [31:0] ad_out,
  input  wire logic [3:0]  low_addr_out,
  input  wire logic        low_addr_oe,
  input  wire logic        ale,
  input  wire logic        diag,
  input  wire logic        data_drive_permit,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [3:0]  straps,
  output logic      [31:0] ad_in,
  output logic      [3:0]  low_addr_in,
  output logic             data_ack,
  output logic      [31:0] lat_addr,
  output logic      [31:0] wr_word,
  output logic      [1:0]  diag_seen,
  output logic      [3:0]  first_la,
  output int               pieces
);
  logic [2:0] wait_cnt = 3'h0;
  logic       strb_q = 1'b0;
  initial ad_in = 32'h0000_0000;
  initial data_ack = 1'b0;
  initial pieces = 0;

  assign low_addr_in = low_addr_oe ? low_addr_out : straps;

  always @(posedge clk_sys) begin
    strb_q <= !rd_n || !wr_n;
    if (ale) begin
      lat_addr <= ad_out;
      diag_seen[1] <= diag;
      pieces <= 0;
    end
    if (!strb_q && (!rd_n || !wr_n)) begin
      pieces <= pieces + 1;
      if (pieces == 0) first_la <= low_addr_out;
      if (!rd_n) diag_seen[0] <= diag;
    end
    if (rd_n && wr_n) begin
      data_ack <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (wait_cnt == (slow ? 3'h5 : 3'h1)) begin
      data_ack <= 1'b1;
      if (!wr_n) wr_word <= ad_out;
    end else wait_cnt <= wait_cnt + 3'h1;
    // Released bus toggles so stale data never looks valid
    if (data_drive_permit && !rd_n) ad_in <= {8{low_addr_out}};
    else ad_in <= ~ad_in;
  end
endmodule // ext_mem_model

/* testbench/muxed_addr_data_bus_port_tb_top.sv */
/*
  Self-checking bench for the bus port.
  Bench is the one AHB-Lite master; ext_mem_model plays the memory.
*/
`timescale 1ns/10ps
`include "bus_port_params.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %0h got %0h", n, e, a); end end

module muxed_addr_data_bus_port_tb_top;
  logic [3:0]  straps = 4'hA;
  logic        clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        ad_oe, low_addr_oe, ale, diag, data_drive_permit;
  logic        rd_n, wr_n, data_ack, slow;
  logic [1:0]  htrans, diag_seen;
  logic [2:0]  hsize;
  logic [3:0]  low_addr_in, low_addr_out, first_la;
  logic [31:0] haddr, hwdata, hrdata, ad_in, ad_out, lat_addr, wr_word;
  logic [31:0] rdv;
  int          pieces, n_mismatch, total_checks;

  assign hready = hreadyout;
  muxed_addr_data_bus_port DUT (.clk_sys, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout,
    .hresp, .ad_in, .ad_out, .ad_oe, .low_addr_in, .low_addr_out,
    .low_addr_oe, .ale, .diag, .data_drive_permit, .rd_n, .wr_n,
    .data_ack);
  ext_mem_model mem (.clk_sys, .slow, .ad_out, .low_addr_out,
    .low_addr_oe, .ale, .diag, .data_drive_permit, .rd_n, .wr_n,
    .straps, .ad_in, .low_addr_in, .data_ack, .lat_addr, .wr_word,
    .diag_seen, .first_la, .pieces);

  //////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rdv = hrdata;
  endtask

  // Start a command, then poll busy with a bounded count
  task automatic go(input logic [31:0] cmd);
    ahb(1'b1, 32'(`OFS_CMD), cmd);
    rdv = 32'h0000_0001;
    for (int i = 0; i < 100 && rdv[0] !== 1'b0; i++)
      ahb(1'b0, 32'(`OFS_STATUS), 32'h0000_0000);
    `CHK("busy cleared", 1'b0, rdv[0])
    `CHK("done flag", 1'b1, rdv[1])
  endtask

  task automatic t_straps;
    ahb(1'b0, 32'(`OFS_STATUS), 32'h0000_0000);
    `CHK("straps", straps, rdv[7:4])
    `CHK("okay resp", 1'b0, hresp)
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rdv)
    $display("test straps done");
  endtask

  task automatic t_write;
    ahb(1'b1, 32'(`OFS_CTRL), 32'h0000_0000);
    ahb(1'b1, 32'(`OFS_ADDR), 32'h0000_1238);
    ahb(1'b1, 32'(`OFS_WDATA), 32'hCAFE_F00D);
    go(32'h0000_0011);
    `CHK("store data", 32'hCAFE_F00D, wr_word)
    `CHK("high addr", 28'h000_0123, lat_addr[31:4])
    `CHK("lane strobes", 4'h0, lat_addr[3:0])
    `CHK("write low addr", 4'h8, first_la)
    $display("test write done");
  endtask

  task automatic t_burst;
    slow <= 1'b1;
    ahb(1'b1, 32'(`OFS_CTRL), 32'h0000_0008);
    ahb(1'b1, 32'(`OFS_ADDR), 32'h0000_0100);
    go(32'h0000_0077);
    `CHK("held strobes", 4'hF, lat_addr[3:0])
    `CHK("diag miss fetch", 2'b11, diag_seen)
    `CHK("burst pieces", 4, pieces)
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 32'(`OFS_RBUF) + 32'(4 * i), 32'h0000_0000);
      `CHK("burst word", {8{i[1:0], 2'b00}}, rdv)
    end
    $display("test burst done");
  endtask

  task automatic t_half;
    slow <= 1'b0;
    ahb(1'b1, 32'(`OFS_CTRL), 32'h0000_0001);
    ahb(1'b1, 32'(`OFS_ADDR), 32'h0000_0004);
    go(32'h0000_0013);
    `CHK("diag data read", 2'b00, diag_seen)
    `CHK("half pieces", 2, pieces)
    `CHK("half first addr", 4'h4, first_la)
    ahb(1'b0, 32'(`OFS_RBUF) + 32'h4, 32'h0000_0000);
    `CHK("half word", 32'h6666_4444, rdv)
    $display("test halfword done");
  endtask

  // Big-endian bytes on a 32-bit port stay on their own lanes
  task automatic t_byte;
    ahb(1'b1, 32'(`OFS_CTRL), 32'h0000_0004);
    ahb(1'b1, 32'(`OFS_ADDR), 32'h0000_2001);
    ahb(1'b1, 32'(`OFS_WDATA), 32'h1122_3344);
    go(32'h0000_0001);
    `CHK("byte strobes", 4'hB, lat_addr[3:0])
    `CHK("byte lane data", 32'h0022_0000, wr_word)
    `CHK("byte pieces", 1, pieces)
    `CHK("byte low addr", 4'h1, first_la)
    ahb(1'b1, 32'(`OFS_ADDR), 32'h0000_2003);
    go(32'h0000_0003);
    `CHK("byte read strobes", 4'hE, lat_addr[3:0])
    ahb(1'b0, 32'(`OFS_RBUF), 32'h0000_0000);
    `CHK("byte read word", 32'h0000_0033, rdv)
    $display("test byte done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    #400_000;
    n_mismatch++;
    close_out();
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    hsize = 3'b010;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_straps();
    t_write();
    t_burst();
    t_half();
    t_byte();
    close_out();
  end
endmodule // muxed_addr_data_bus_port_tb_top
